// ==== fcc_top.v ====
// Purpose: fan unit configuration registers and output control
// Assumes: Avalon-MM slave, word address = register index
// Notes: duty generators are outside; their raw pwm enters here
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fcc_regs.vh"
module fcc_top (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire dev_active,
    input wire [2:0] pwm_raw,
    input wire [1:0] overtemp_alarm,
    input wire [2:0] tach_in,
    output wire [2:0] fan_pwm_out,
    output wire [2:0] fan_pwm_oe_n,
    output wire [2:0] ctl_enable,
    output wire [2:0] mon_enable,
    output wire [2:0] tach_pulse
);
    reg [7:0] cfg_one_q;
    reg [7:0] cfg_two_q;
    reg [7:0] force_q;
    reg ack_q;
    reg [7:0] rd_d;
    wire [2:0] inv;
    wire [2:0] pwm_q;
    wire [2:0] tach_lvl;
    wire alarm;
    wire req;
    genvar gi;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // one wait cycle keeps read data registered
    assign req = (avs_read | avs_write) & clk_en;
    assign avs_waitrequest = ~ack_q;

    always @* begin
        case (avs_address)
            `FCC_IDX_CFG_ONE: rd_d = cfg_one_q;
            `FCC_IDX_CFG_TWO: rd_d = cfg_two_q;
            `FCC_IDX_FORCE: rd_d = force_q;
            `FCC_IDX_STATUS: rd_d = {4'h0, alarm, tach_lvl};
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            cfg_one_q <= `FCC_RESET_VAL;
            cfg_two_q <= `FCC_RESET_VAL;
            force_q <= `FCC_RESET_VAL;
            ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                avs_readdata <= {24'h000000, rd_d};
                if (avs_write && avs_byteenable[0]) begin
                    case (avs_address)
                        `FCC_IDX_CFG_ONE:
                            cfg_one_q <= avs_writedata[7:0] & `FCC_CFG_ONE_MASK;
                        `FCC_IDX_CFG_TWO:
                            cfg_two_q <= avs_writedata[7:0] & `FCC_CFG_TWO_MASK;
                        `FCC_IDX_FORCE:
                            force_q <= avs_writedata[7:0] & `FCC_FORCE_MASK;
                        default: ;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // channel decode
    // ----------------------------------------
    assign alarm = |overtemp_alarm;
    assign inv = {cfg_two_q[`FCC_B2_INV2], cfg_one_q[`FCC_B1_INV1], cfg_one_q[`FCC_B1_INV0]};
    assign ctl_enable = {cfg_two_q[`FCC_B2_CTL2], cfg_one_q[`FCC_B1_CTL1], cfg_one_q[`FCC_B1_CTL0]};
    assign mon_enable = {cfg_two_q[`FCC_B2_MON2], cfg_one_q[`FCC_B1_MON1], cfg_one_q[`FCC_B1_MON0]};

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
            fcc_chan u_chan (
                .clk(clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .pwm_raw(pwm_raw[gi]),
                .ctl_en(ctl_enable[gi]),
                .mon_en(mon_enable[gi]),
                .inv_en(inv[gi]),
                .force_en(force_q[gi]),
                .alarm(alarm),
                .tach_in(tach_in[gi]),
                .pwm_q(pwm_q[gi]),
                .tach_level(tach_lvl[gi]),
                .tach_pulse_q(tach_pulse[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // release pins only when tri option set and device inactive
    assign fan_pwm_out = pwm_q;
    assign fan_pwm_oe_n = {3{cfg_one_q[`FCC_B1_TRI] & ~dev_active}};
endmodule
`default_nettype wire

// ==== fcc_regs.vh ====
// Purpose: constants for the fan configuration block
// Assumes: 8-bit registers on 32-bit Avalon-MM words, word address equals index
// Notes: included by fcc_top.v and fcc_chan.v
//
// Contract
// - config one at index F0h, resets to 00h, all options off.
// - config one bit 7 inverts channel 1 output.
// - config one bit 6 enables channel 1 speed control.
// - config one bit 5 enables channel 1 speed monitor.
// - config one bit 4 inverts channel 0 output.
// - config one bit 3 enables channel 0 speed control.
// - config one bit 2 enables channel 0 speed monitor.
// - config one bit 0 plus inactive device puts fan pins in high impedance.
// - config two at index F1h, resets to 00h, bits 7..3 reserved.
// - config two bit 2 inverts channel 2 output.
// - config two bit 1 enables channel 2 speed control.
// - config two bit 0 enables channel 2 speed monitor.
// - force register at F2h, bit 0 forces channel 0 full duty on alarm.
// - force bit 1 forces channel 1 full duty on alarm.
// - force bit 2 forces channel 2 full duty on alarm.
// - alarm condition is OR of all over-temperature outputs.
// - with speed control on and without force or alarm, output follows normal PWM generator.
// - three independent control and three independent monitor channels.
`ifndef FCC_REGS_VH
`define FCC_REGS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define FCC_IDX_CFG_ONE 8'hF0
`define FCC_IDX_CFG_TWO 8'hF1
`define FCC_IDX_FORCE 8'hF2
`define FCC_IDX_STATUS 8'hF3
`define FCC_RESET_VAL 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FCC_B1_INV1 7
`define FCC_B1_CTL1 6
`define FCC_B1_MON1 5
`define FCC_B1_INV0 4
`define FCC_B1_CTL0 3
`define FCC_B1_MON0 2
`define FCC_B1_TRI 0
`define FCC_B2_INV2 2
`define FCC_B2_CTL2 1
`define FCC_B2_MON2 0
`define FCC_CFG_ONE_MASK 8'hFD
`define FCC_CFG_TWO_MASK 8'h07
`define FCC_FORCE_MASK 8'h07

`endif

// ==== fcc_chan.v ====
// Purpose: one fan channel, output shaping and tach sampling
// Assumes: pwm_raw comes from the duty generator on clk
// Notes: tach comes from a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "fcc_regs.vh"
module fcc_chan (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire pwm_raw,
    input wire ctl_en,
    input wire mon_en,
    input wire inv_en,
    input wire force_en,
    input wire alarm,
    input wire tach_in,
    output reg pwm_q,
    output wire tach_level,
    output reg tach_pulse_q
);
    reg sync1_q;
    reg sync2_q;
    reg sync3_q;
    reg level_q;
    reg pwm_d;

    // ----------------------------------------
    // output shaping
    // ----------------------------------------
    always @* begin
        pwm_d = 1'b0;
        if (ctl_en) begin
            if (force_en && alarm)
                pwm_d = 1'b1;
            else
                pwm_d = pwm_raw;
        end
        if (inv_en)
            pwm_d = ~pwm_d;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            pwm_q <= 1'b0;
            // tach idles high: resetting high avoids a false edge
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
            level_q <= 1'b1;
            tach_pulse_q <= 1'b0;
        end else if (clk_en) begin
            pwm_q <= pwm_d;
            sync1_q <= tach_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            tach_pulse_q <= 1'b0;
            // change counted only when stages two and three agree
            if (sync2_q == sync3_q && sync3_q != level_q) begin
                level_q <= sync3_q;
                tach_pulse_q <= mon_en & sync3_q;
            end
        end
    end

    assign tach_level = level_q;
endmodule
`default_nettype wire

// ==== fcc_props_properties.sv ====
// Purpose: port checker for fcc_top
// Assumes: one clock, sync reset
// Notes: config bits are seen through enables
`timescale 1ns/1ps
`default_nettype none
module fcc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic dev_active,
    input wire logic [2:0] fan_pwm_out,
    input wire logic [2:0] fan_pwm_oe_n,
    input wire logic [2:0] ctl_enable,
    input wire logic [2:0] mon_enable,
    input wire logic [2:0] tach_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic tk = avs_write && avs_byteenable[0] && !avs_waitrequest;
    wire logic [7:0] wd = avs_writedata[7:0];
    property p_c1; tk && avs_address == 8'hF0 |-> {ctl_enable[1:0], mon_enable[1:0]} == {wd[6], wd[3], wd[5], wd[2]};
    endproperty
    a_c1: assert property (p_c1) else $error("config one enables wrong");
    property p_c2; tk && avs_address == 8'hF1 |-> {ctl_enable[2], mon_enable[2]} == wd[1:0]; endproperty
    a_c2: assert property (p_c2) else $error("config two enables wrong");
    property p_ans; (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer after one wait");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer held too long");
    property p_unm; avs_read && !avs_waitrequest && (avs_address < 8'hF0 || avs_address > 8'hF3) |-> avs_readdata == 0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_tri; dev_active |-> fan_pwm_oe_n == 3'h0; endproperty
    a_tri: assert property (p_tri) else $error("pins released while active");
    property p_tach; (tach_pulse & ~mon_enable & ~$past(mon_enable)) == 3'h0; endproperty
    a_tach: assert property (p_tach) else $error("tach pulse with monitor off");
    property p_rst; $past(sys_rst) |-> {ctl_enable, mon_enable, fan_pwm_out} == 9'h0; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule
bind fcc_top fcc_props u_props (.clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dev_active, .fan_pwm_out, .fan_pwm_oe_n, .ctl_enable,
    .mon_enable, .tach_pulse);
`default_nettype wire

// ==== fcc_fan_model.sv ====
// Purpose: behavioural fans with tach feedback
// Assumes: a fan spins only while its pin is driven high
// Notes: tach idles high, board pull-up
`timescale 1ns/1ps
`default_nettype none
module fcc_fan_model (
    input wire logic clk,
    input wire logic [2:0] pwm,
    input wire logic [2:0] oe_n,
    output logic [2:0] tach = 3'h7
);
    logic [11:0] cnt_q = 12'h000;
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt_q[4*i+:4] <= cnt_q[4*i+:4] + {3'h0, pwm[i] & ~oe_n[i]};
            tach[i] <= ~cnt_q[4*i+3];
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for fcc_top
// Assumes: clk_en and byteenable held on
// Notes: reads checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, dev_active = 0;
    logic [7:0] avs_address = 8'h00, c1, c2, fr;
    logic [31:0] avs_writedata = 32'h0;
    logic [2:0] pwm_raw = 3'h0, e;
    logic [1:0] overtemp_alarm = 2'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [2:0] fan_pwm_out, fan_pwm_oe_n, ctl_enable, mon_enable, tach_pulse, tach_in;
    int error_cnt = 0, checked = 0, p0 = 0, p12 = 0;
    logic [31:0] exp_q [$];
    logic [7:0] ad [4] = '{8'hF0, 8'hF1, 8'hF2, 8'hF5};
    logic [7:0] wm [4] = '{8'hFD, 8'h07, 8'h07, 8'h00};
    fcc_top dut (.clk, .sys_rst, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .dev_active, .pwm_raw, .overtemp_alarm,
        .tach_in, .fan_pwm_out, .fan_pwm_oe_n, .ctl_enable, .mon_enable, .tach_pulse);
    fcc_fan_model fan (.clk, .pwm(fan_pwm_out), .oe_n(fan_pwm_oe_n), .tach(tach_in));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // held until waitrequest seen low, released after that edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= rd;
        avs_write <= ~rd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                summarize();
            end
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    always @(negedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
    end
    initial begin
        void'($urandom(32'h7F10));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(32'h0);
            bus(1, ad[i], 8'h00);
            bus(0, ad[i], 8'hFF);
            exp_q.push_back({24'h0, wm[i]});
            bus(1, ad[i], 8'h00);
        end
        // status: fans stopped, tach high, no alarm; writes ignored
        bus(0, 8'hF3, 8'hFF);
        exp_q.push_back(32'h7);
        bus(1, 8'hF3, 8'h00);
        // 60 rounds of random settings sample the mode mixes
        repeat (60) begin
            c1 = $urandom;
            c2 = $urandom;
            fr = $urandom;
            bus(0, 8'hF0, c1);
            bus(0, 8'hF1, c2);
            bus(0, 8'hF2, fr);
            pwm_raw <= $urandom;
            overtemp_alarm <= $urandom;
            dev_active <= $urandom;
            repeat (3) @(negedge clk);
            e = {c2[1], c1[6], c1[3]} & (fr[2:0] & {3{|overtemp_alarm}} | pwm_raw);
            chk(32'(fan_pwm_out), 32'(e ^ {c2[2], c1[7], c1[4]}));
            chk(32'(ctl_enable), 32'({c2[1], c1[6], c1[3]}));
            chk(32'(mon_enable), 32'({c2[0], c1[5], c1[2]}));
            chk(32'(fan_pwm_oe_n), 32'({3{c1[0] & ~dev_active}}));
            @(posedge clk);
        end
        // directed monitor run: channel 0 spinning, others off
        dev_active <= 1'b1;
        overtemp_alarm <= 2'h0;
        bus(0, 8'hF1, 8'h00);
        bus(0, 8'hF0, 8'h0C);
        pwm_raw <= 3'h1;
        repeat (160) begin
            @(posedge clk);
            if (tach_pulse[0]) p0++;
            if (tach_pulse[2:1] != 2'h0) p12++;
        end
        chk(32'(p0 != 0), 32'h1);
        chk(32'(p12), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
